// [common/sram_port_pkg.sv]
// package for the synchronous burst memory port: sizes, codes, apb map and reset values
// assumes one clock domain (pclk) and an apb master with 32-bit data
package sram_port_pkg;

  // ==========================================================================
  // array geometry
  localparam int unsigned ADDR_W  = 17;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned LANES   = 4;
  localparam int unsigned LANE_W  = 9;
  localparam int unsigned WORD_W  = 36;
  localparam int unsigned DEPTH   = 131072;
  localparam int unsigned STEP_W  = 2;

  localparam logic [STEP_W-1:0] STEP_FIRST = 2'h0;
  localparam logic [STEP_W-1:0] STEP_ONE   = 2'h1;
  localparam logic [LANES-1:0]  LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0]  LANES_NONE = 4'h0;

  // ==========================================================================
  // burst order strap; an open strap reads as interleaved (internal pull-up)
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_RST    = 1'b1;

  // ==========================================================================
  // port states, one-hot
  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_SLEEP = 4'h8
  } port_state_e;

  // ==========================================================================
  // apb register map
  localparam int unsigned    APB_AW      = 12;
  localparam logic [11:0]    CTRL_OFS    = 12'h000;
  localparam logic [11:0]    STATUS_OFS  = 12'h004;
  localparam logic [31:0]    CTRL_RST    = 32'h0000_0000;
  localparam int unsigned    CTRL_WBLOCK = 0;
  localparam int unsigned    STAT_ADDR   = 0;
  localparam int unsigned    STAT_STATE  = 17;
  localparam int unsigned    STAT_ORDER  = 21;
  localparam int unsigned    STAT_DRIVE  = 22;
  localparam int unsigned    STAT_SLEEP  = 23;

endpackage : sram_port_pkg

// [rtl/burst_seq.sv]
// burst address sequencer: start value and step count give the low address bits
// purely combinational: start and step may be the caller's registers or its next-state values
`timescale 1ns/1ns
module burst_seq #(
  parameter int unsigned W = 2
) (
  input  wire logic [W-1:0] start,
  input  wire logic [W-1:0] step,
  input  wire logic         interleaved,
  output logic      [W-1:0] low_addr
);

  // ==========================================================================
  // sequence; both forms stay inside the aligned block, no carry upward
  always_comb begin
    if (interleaved) begin
      low_addr = start ^ step;
    end else begin
      low_addr = W'(start + step);
    end
  end

endmodule : burst_seq

// [rtl/lane_merge.sv]
// per-lane merge of a new word over an old one, lane enables active high
// assumes each lane carries its data byte and its parity bit together
`timescale 1ns/1ns
module lane_merge #(
  parameter int unsigned LANES  = 4,
  parameter int unsigned LANE_W = 9
) (
  input  wire logic [LANES*LANE_W-1:0] old_word,
  input  wire logic [LANES*LANE_W-1:0] new_word,
  input  wire logic [LANES-1:0]        lane_en,
  output logic      [LANES*LANE_W-1:0] merged
);

  // ==========================================================================
  // lane x of the enable picks lane x of the word, parity included
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign merged[i*LANE_W +: LANE_W] = lane_en[i] ? new_word[i*LANE_W +: LANE_W]
                                                   : old_word[i*LANE_W +: LANE_W];
  end

endmodule : lane_merge

// [rtl/sync_burst_sram_port.sv]
// synchronous pipelined burst memory port with byte writes, sleep and an apb window
// assumes all pins are synchronous to pclk except the output enable; the sleep level is sampled on pclk like the rest
`timescale 1ns/1ns
module sync_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [APB_AW-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic               select_a_n,
  input  wire logic               select_b,
  input  wire logic               select_c_n,
  input  wire logic               cpu_addr_strobe_n,
  input  wire logic               ctrl_addr_strobe_n,
  input  wire logic               burst_step_n,
  input  wire logic               all_bytes_write_n,
  input  wire logic               lane_write_qual_n,
  input  wire logic [LANES-1:0]   lane_select_n,
  input  wire logic               out_enable_n,
  input  wire logic               sleep_req,
  input  wire logic               burst_order,
  input  wire logic [DATA_W-1:0]  data_in,
  output logic      [DATA_W-1:0]  data_out,
  output logic                    data_oe,
  input  wire logic [LANES-1:0]   parity_in,
  output logic      [LANES-1:0]   parity_out,
  output logic                    parity_oe
);

  // ==========================================================================
  // declarations
  port_state_e              state;
  port_state_e              next_state;
  logic [ADDR_W-1:0]        base;
  logic [ADDR_W-1:0]        next_base;
  logic [STEP_W-1:0]        start;
  logic [STEP_W-1:0]        next_start;
  logic [STEP_W-1:0]        step;
  logic [STEP_W-1:0]        next_step;
  logic                     wr_pend;
  logic                     next_wr_pend;
  logic [ADDR_W-1:0]        wr_addr;
  logic [ADDR_W-1:0]        next_wr_addr;
  logic [WORD_W-1:0]        wr_word;
  logic [WORD_W-1:0]        next_wr_word;
  logic [LANES-1:0]         wr_lanes;
  logic [LANES-1:0]         next_wr_lanes;
  logic                     drive;
  logic                     next_drive;
  logic [DATA_W-1:0]        next_data_out;
  logic [LANES-1:0]         next_parity_out;
  logic                     order;
  logic                     next_order;
  logic                     strap_done;
  logic [31:0]              ctrl;
  logic [31:0]              next_ctrl;
  logic [31:0]              next_prdata;
  logic                     next_pready;
  logic                     next_pslverr;
  logic                     cpu_go;
  logic                     ctrl_go;
  logic                     sel_ok;
  logic [LANES-1:0]         lanes_req;
  logic [STEP_W-1:0]        cur_low;
  logic [STEP_W-1:0]        nxt_low;
  logic [ADDR_W-1:0]        cur_addr;
  logic [ADDR_W-1:0]        next_addr;
  logic [WORD_W-1:0]        in_word;
  logic [WORD_W-1:0]        mem_word;
  logic [WORD_W-1:0]        wr_merged;
  logic [WORD_W-1:0]        rd_merged;
  logic [WORD_W-1:0]        rd_word;
  logic [WORD_W-1:0]        mem [DEPTH];

  // ==========================================================================
  // pin decode; strobes and selects are only looked at together
  assign sel_ok  = !select_a_n && select_b && !select_c_n;
  assign cpu_go  = !cpu_addr_strobe_n && !select_a_n;
  assign ctrl_go = !ctrl_addr_strobe_n && !cpu_go;
  assign lanes_req = ctrl[CTRL_WBLOCK] ? LANES_NONE
                   : !all_bytes_write_n ? LANES_ALL
                   : !lane_write_qual_n ? ~lane_select_n
                   : LANES_NONE;

  for (genvar i = 0; i < LANES; i++) begin : g_pack
    assign in_word[i*LANE_W +: LANE_W] = {parity_in[i], data_in[i*8 +: 8]};
    assign next_data_out[i*8 +: 8]     = rd_word[i*LANE_W +: 8];
    assign next_parity_out[i]          = rd_word[i*LANE_W + 8];
  end

  // ==========================================================================
  // burst address, current and next
  burst_seq #(.W(STEP_W)) u_cur_seq (
    .start       (start),
    .step        (step),
    .interleaved (order),
    .low_addr    (cur_low)
  );

  burst_seq #(.W(STEP_W)) u_next_seq (
    .start       (next_start),
    .step        (next_step),
    .interleaved (order),
    .low_addr    (nxt_low)
  );

  assign cur_addr  = {base[ADDR_W-1:STEP_W], cur_low};
  assign next_addr = {next_base[ADDR_W-1:STEP_W], nxt_low};

  // ==========================================================================
  // access control
  always_comb begin
    next_state    = state;
    next_base     = base;
    next_start    = start;
    next_step     = step;
    next_wr_pend  = 1'b0;
    next_wr_addr  = wr_addr;
    next_wr_word  = wr_word;
    next_wr_lanes = wr_lanes;
    if (sleep_req) begin
      // no new access is taken; a write already pending still lands in the array
      next_state = ST_SLEEP;
    end else if (cpu_go || ctrl_go) begin
      if (!sel_ok) begin
        next_state = ST_DESEL;
      end else begin
        next_base  = addr;
        next_start = addr[STEP_W-1:0];
        next_step  = STEP_FIRST;
        // a cpu-started access ignores the write pins on its first edge
        if (ctrl_go && lanes_req != LANES_NONE) begin
          next_state    = ST_WRITE;
          next_wr_pend  = 1'b1;
          next_wr_addr  = addr;
          next_wr_word  = in_word;
          next_wr_lanes = lanes_req;
        end else begin
          next_state = ST_READ;
        end
      end
    end else if (state == ST_READ || state == ST_WRITE) begin
      if (lanes_req != LANES_NONE) begin
        next_state    = ST_WRITE;
        next_wr_pend  = 1'b1;
        next_wr_addr  = cur_addr;
        next_wr_word  = in_word;
        next_wr_lanes = lanes_req;
      end else begin
        next_state = ST_READ;
      end
      if (!burst_step_n) begin
        next_step = STEP_W'(step + STEP_ONE);
      end
    end else if (state == ST_SLEEP) begin
      next_state = ST_DESEL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_DESEL;
      base     <= '0;
      start    <= STEP_FIRST;
      step     <= STEP_FIRST;
      wr_pend  <= 1'b0;
      wr_addr  <= '0;
      wr_word  <= '0;
      wr_lanes <= LANES_NONE;
    end else begin
      state    <= next_state;
      base     <= next_base;
      start    <= next_start;
      step     <= next_step;
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      wr_word  <= next_wr_word;
      wr_lanes <= next_wr_lanes;
    end
  end

  // ==========================================================================
  // array: the write lands one edge after its request, so reads bypass it
  assign mem_word = mem[wr_addr];

  lane_merge #(.LANES(LANES), .LANE_W(LANE_W)) u_wr_merge (
    .old_word (mem_word),
    .new_word (wr_word),
    .lane_en  (wr_lanes),
    .merged   (wr_merged)
  );

  lane_merge #(.LANES(LANES), .LANE_W(LANE_W)) u_rd_merge (
    .old_word (mem[next_addr]),
    .new_word (wr_word),
    .lane_en  ((wr_pend && wr_addr == next_addr) ? wr_lanes : LANES_NONE),
    .merged   (rd_merged)
  );

  always_ff @(posedge pclk) begin
    if (wr_pend) begin
      mem[wr_addr] <= wr_merged;
    end
  end

  // ==========================================================================
  // read pipeline and pin drive
  always_comb begin
    rd_word    = rd_merged;
    // no drive on the first read clock out of deselect, nor on any write
    next_drive = (next_state == ST_READ) &&
                 (state == ST_READ || state == ST_WRITE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out   <= '0;
      parity_out <= '0;
      drive      <= 1'b0;
    end else begin
      data_out   <= next_data_out;
      parity_out <= next_parity_out;
      drive      <= next_drive;
    end
  end

  // the enable is asynchronous, so it gates the registered drive directly
  assign data_oe   = drive && !out_enable_n;
  assign parity_oe = drive && !out_enable_n;

  // ==========================================================================
  // order strap, caught once after reset release
  always_comb begin
    next_order = strap_done ? order : burst_order;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order      <= ORDER_RST;
      strap_done <= 1'b0;
    end else begin
      order      <= next_order;
      strap_done <= 1'b1;
    end
  end

  // ==========================================================================
  // apb slave, one wait-free access cycle after setup
  always_comb begin
    next_ctrl    = ctrl;
    next_pready  = psel && !penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (psel && !penable && !pready) begin
      case (paddr)
        CTRL_OFS: begin
          next_prdata = ctrl;
        end
        STATUS_OFS: begin
          next_prdata[STAT_ADDR +: ADDR_W] = cur_addr;
          next_prdata[STAT_STATE +: 4]     = state;
          next_prdata[STAT_ORDER]          = order;
          next_prdata[STAT_DRIVE]          = drive;
          next_prdata[STAT_SLEEP]          = state == ST_SLEEP;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
      next_ctrl              = CTRL_RST;
      next_ctrl[CTRL_WBLOCK] = pwdata[CTRL_WBLOCK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= CTRL_RST;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sel_load;
    !sleep_req && (cpu_go || ctrl_go) && sel_ok;
  endsequence

  sequence s_burst_cont;
    !sleep_req && !cpu_go && !ctrl_go && (state == ST_READ || state == ST_WRITE);
  endsequence

  a_strobe_load: assert property (s_sel_load |=> base == $past(addr) && step == STEP_FIRST
                                  && start == $past(addr[1:0]))
    else $error("address load missed");
  a_burst_adv: assert property (s_burst_cont ##0 !burst_step_n |=>
                                step == 2'($past(step) + 2'h1))
    else $error("burst did not advance");
  a_burst_hold: assert property (s_burst_cont ##0 burst_step_n |=> $stable(step))
    else $error("burst moved while held");
  a_cpu_ignored: assert property (!sleep_req && !cpu_addr_strobe_n && select_a_n
                                  && ctrl_addr_strobe_n |=> $stable(base) && $stable(start))
    else $error("cpu strobe acted while unselected");
  a_cpu_wins: assert property (s_sel_load ##0 !cpu_addr_strobe_n && !ctrl_addr_strobe_n
                               |=> state == ST_READ && !wr_pend)
    else $error("controller strobe acted beside cpu strobe");
  a_first_mask: assert property ((state == ST_DESEL) ##1 (state == ST_READ) |-> !data_oe)
    else $error("pins driven on first read clock");
  a_oe_masks: assert property (out_enable_n || state == ST_WRITE |-> !data_oe && !parity_oe)
    else $error("pins driven with enable high");
  a_global_write: assert property (s_sel_load ##0 ctrl_go && !all_bytes_write_n
                                   && !ctrl[CTRL_WBLOCK] |=> wr_pend && wr_lanes == LANES_ALL)
    else $error("global write not all lanes");
  a_lane_write: assert property (s_burst_cont ##0 all_bytes_write_n && !lane_write_qual_n
                                 && !ctrl[CTRL_WBLOCK] && lane_select_n != LANES_ALL
                                 |=> wr_lanes == ~$past(lane_select_n))
    else $error("lane write mask wrong");
  a_wrap_block: assert property (s_burst_cont |=> base[ADDR_W-1:2] == $past(base[ADDR_W-1:2]))
    else $error("burst left its block");

endmodule : sync_burst_sram_port

// [tb/mem_master.sv]
// pin-side master model: drives strobes, selects, write qualifiers and the data bus
// assumes the bench calls put once per clock; values are sampled at the following edge
`timescale 1ns/1ns
module mem_master
  import sram_port_pkg::*;
(
  input  wire logic              pclk,
  output logic      [ADDR_W-1:0] addr,
  output logic                   select_a_n,
  output logic                   select_b,
  output logic                   select_c_n,
  output logic                   cpu_addr_strobe_n,
  output logic                   ctrl_addr_strobe_n,
  output logic                   burst_step_n,
  output logic                   all_bytes_write_n,
  output logic                   lane_write_qual_n,
  output logic      [LANES-1:0]  lane_select_n,
  output logic                   out_enable_n,
  output logic      [DATA_W-1:0] data_in,
  output logic      [LANES-1:0]  parity_in,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  input  wire logic [LANES-1:0]  parity_out,
  input  wire logic              parity_oe
);
  logic [DATA_W-1:0] drv_d;
  logic [LANES-1:0]  drv_p;

  // ==========================================================================
  // shared wire: the port wins while it drives
  assign data_in   = data_oe ? data_out : drv_d;
  assign parity_in = parity_oe ? parity_out : drv_p;

  initial begin
    {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
    {all_bytes_write_n, lane_write_qual_n, out_enable_n}  = 3'h7;
    {select_a_n, select_b, select_c_n} = 3'h4;
    lane_select_n = 4'hF;
    addr  = '0;
    drv_d = '0;
    drv_p = '0;
  end

  // ==========================================================================
  // k bit0 cpu strobe, bit1 controller strobe; s {a_n,b,c_n}; w {all_n,qual_n,lanes_n}
  task put(input logic [1:0] k, input logic [2:0] s, input logic [ADDR_W-1:0] a,
           input logic [5:0] w, input logic [35:0] dp, input logic [1:0] so);
    @(posedge pclk);
    cpu_addr_strobe_n  <= ~k[0];
    ctrl_addr_strobe_n <= ~k[1];
    {select_a_n, select_b, select_c_n} <= s;
    addr <= (k != 2'h0) ? a : ~addr;
    {all_bytes_write_n, lane_write_qual_n, lane_select_n} <= w;
    {burst_step_n, out_enable_n} <= so;
    // outside a write the bus keeps moving, so stale data never looks valid
    {drv_p, drv_d} <= (w[5:4] != 2'h3) ? dp : ~{drv_p, drv_d};
  endtask : put
endmodule : mem_master

// [tb/sync_burst_sram_port_bench.sv]
// self-checking bench for the burst memory port: apb window plus pin-side master model
// assumes the package constants and the hand-over timing of the port
`timescale 1ns/1ns
module sync_burst_sram_port_bench
  import sram_port_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd_v;
  logic              sleep_req, burst_order, select_a_n, select_b, select_c_n;
  logic              cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, blocked;
  logic              all_bytes_write_n, lane_write_qual_n, out_enable_n, data_oe, parity_oe;
  logic [ADDR_W-1:0] addr, base;
  logic [LANES-1:0]  lane_select_n, parity_in, parity_out;
  logic [DATA_W-1:0] data_in, data_out;
  int                errors, samples_checked, seed;
  logic [35:0]       mem_m [int];
  logic [35:0]       exp_q [$];

  sync_burst_sram_port uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .addr, .select_a_n, .select_b, .select_c_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .all_bytes_write_n, .lane_write_qual_n, .lane_select_n, .out_enable_n,
    .sleep_req, .burst_order, .data_in, .data_out, .data_oe, .parity_in, .parity_out,
    .parity_oe
  );
  mem_master m (
    .pclk, .addr, .select_a_n, .select_b, .select_c_n, .cpu_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_step_n, .all_bytes_write_n, .lane_write_qual_n,
    .lane_select_n, .out_enable_n, .data_in, .parity_in, .data_out, .data_oe,
    .parity_out, .parity_oe
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================================
  // checking and closing
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task stop_test;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // read words leave the queue in the order the burst should visit them
  always @(negedge pclk) begin
    if (data_oe === 1'b1 && exp_q.size() > 0) begin
      check("read word", {parity_out, data_out}, exp_q.pop_front());
    end
  end

  initial begin
    #400000;
    errors++;
    stop_test();
  end

  // ==========================================================================
  // bus tasks
  function automatic logic [35:0] rnd36();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction : rnd36

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [ADDR_W-1:0] a, input logic [5:0] w, input logic [35:0] dp);
    if (w[5] && !w[4]) begin
      // lane writes go the cpu way: load with write pins ignored, then write at the held address
      m.put(2'h1, 3'h2, a, 6'h0F, rnd36(), 2'h3);
      m.put(2'h0, 3'h2, a, w, dp, 2'h3);
    end else begin
      m.put(2'h2, 3'h2, a, w, dp, 2'h3);
    end
    // idle edge, so a held write request is not taken again later
    m.put(2'h0, 3'h2, a, 6'h3F, '0, 2'h3);
    for (int l = 0; l < LANES; l++) begin
      if (!blocked && (!w[5] || (!w[4] && !w[l]))) begin
        mem_m[a][8*l +: 8] = dp[8*l +: 8];
        mem_m[a][32+l]     = dp[32+l];
      end
    end
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a);
    logic [1:0] lo;
    m.put(2'h3, 3'h2, a, 6'h0F, rnd36(), 2'h3); // write pins ignored
    m.put(2'h2, 3'h0, a, 6'h3F, '0, 2'h3);
    for (int i = 0; i < 5; i++) begin
      lo = burst_order ? (a[1:0] ^ i[1:0]) : (a[1:0] + i[1:0]);
      exp_q.push_back(mem_m[{a[ADDR_W-1:2], lo}]);
    end
    m.put(2'h1, 3'h2, a, 6'h3F, '0, 2'h2);
    m.put(2'h0, 3'h2, a, 6'h3F, '0, 2'h2);
    @(negedge pclk);
    check("first read clock drive", data_oe, 0);
    repeat (4) m.put(2'h0, 3'h2, a, 6'h3F, '0, 2'h0);
    m.put(2'h0, 3'h2, a, 6'h3F, '0, 2'h2);
    m.put(2'h1, 3'h6, ~a, 6'h3F, '0, 2'h3);
    @(negedge pclk);
    check("drive with enable high", {data_oe, parity_oe}, 0);
    check("reads left", exp_q.size(), 0);
    apb(1'b0, STATUS_OFS, '0);
    check("status", rd_v[21:0], {burst_order, ST_READ, a});
  endtask : rd

  // ==========================================================================
  // main sequence: interleaved pass, then linear pass
  initial begin
    seed = 25714;
    {psel, penable, pwrite, paddr, pwdata, sleep_req, blocked} = '0;
    presetn     = 1'b0;
    burst_order = ORDER_RST;
    errors          = 0;
    samples_checked = 0;
    for (int pass = 0; pass < 2; pass++) begin
      presetn     <= 1'b0;
      burst_order <= pass[0] ? ORDER_LINEAR : ORDER_RST; // static while running
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      mem_m.delete();
      base = ADDR_W'($random(seed));
      for (int i = 0; i < 4; i++) begin
        wr({base[ADDR_W-1:2], i[1:0]}, 6'h1F, rnd36());
      end
      wr({base[ADDR_W-1:2], 2'h1}, {2'h2, 4'($random(seed))}, rnd36());
      wr({base[ADDR_W-1:2], 2'h2}, 6'h30, rnd36());
      apb(1'b1, CTRL_OFS, 32'h0000_0001);
      blocked = 1'b1;
      wr({base[ADDR_W-1:2], 2'h3}, 6'h00, rnd36());
      apb(1'b0, CTRL_OFS, '0);
      check("ctrl readback", rd_v, 32'h0000_0001);
      apb(1'b1, CTRL_OFS, '0);
      blocked = 1'b0;
      apb(1'b0, 12'h008, '0);
      check("unmapped access", {err, rd_v}, {1'b1, 32'h0000_0000});
      rd({base[ADDR_W-1:2], 2'($random(seed))});
      @(posedge pclk);
      sleep_req <= 1'b1;
      apb(1'b0, STATUS_OFS, '0);
      check("sleep status", {rd_v[23], rd_v[20:17]}, {1'b1, ST_SLEEP});
      @(posedge pclk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge pclk);
      rd({base[ADDR_W-1:2], 2'($random(seed))});
    end
    stop_test();
  end
endmodule : sync_burst_sram_port_bench
